// File: ett_trail_trace.sv
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - 16-byte transmit identifier memory, software written, read in order
// - line defects force received trace data to all ones
// - serial bytes go first bit first, as register bit 7
// - transmit identifier memory has no reset
// - transmit reorder off sends bit 7 first, on sends bit 0
// - alignment insertion: first bit one in byte one, zero elsewhere
// - transmit inversion follows reordering and alignment insertion
// - transmit idle sends all zeros
// - receive inversion precedes all other receive processing
// - alignment finds a one, then fifteen zero alignment bits
// - without alignment, bytes stored in order from any byte
// - arrival order; aligned start byte at location zero
// - five identical new non-zero identifiers replace held one, set change
// - idle after five zero identifiers; cleared by five non-zero or unstable
// - unstable after eight unmatched identifiers; cleared by five non-zero or idle
// - mismatch compares seven data bits of all sixteen bytes
// - comparison has own enable, off whenever alignment is off
// - no mismatch before the first held identifier update
// - receive reorder off stores first bit in bit 7, on in bit 0
// - storage reachable from either side; directions independent
// - 48 bytes: current, held and expected identifiers
module ett_trail_trace #(
   parameter int DECLARE_N  = ett_pkg::DECLARE_COUNT,
   parameter int UNSTABLE_N = ett_pkg::UNSTABLE_COUNT
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        datapath_reset_n,
   input  wire logic        line_clk,
   input  wire logic        rx_trace_bit,
   input  wire logic        rx_byte_start,
   input  wire logic        rx_defect,
   input  wire logic        tx_byte_start,
   output logic             tx_trace_bit
);

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   if (DECLARE_N < 1 || DECLARE_N > 15)
      $error("declare count out of range");
   if (UNSTABLE_N < 1 || UNSTABLE_N > 15)
      $error("unstable count out of range");
   if (ett_pkg::LINK_HALF_CYC < ett_pkg::MIN_HALF_CYC)
      $error("line clock too fast for sampling");

   // ****************************************************************
   // helpers
   // ****************************************************************
   // swap bit order of a byte
   function automatic logic [7:0] bit_rev(input logic [7:0] b);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         r[i] = b[7-i];
      end
      return r;
   endfunction

   // saturating increment of a persistence counter
   function automatic logic [3:0] sat_inc(input logic [3:0] c);
      return (c == 4'hF) ? c : c + 4'h1;
   endfunction

   // aligned word inside an identifier window
   function automatic logic in_region(input logic [11:0] a, input logic [11:0] base);
      return (a >= base) && (a < base + ett_pkg::ID_SPAN) && (a[1:0] == 2'b00);
   endfunction

   localparam logic [3:0] DECL_C = 4'(DECLARE_N);
   localparam logic [3:0] UNST_C = 4'(UNSTABLE_N);

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   logic [ett_pkg::SI_WIDTH-1:0] sync1_r;
   logic [ett_pkg::SI_WIDTH-1:0] sync2_r;
   logic                         lclk_d_r;
   logic                         lclk_rise;
   logic                         dp_run;

   // two stages; only the second stage feeds logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r  <= '0;
         sync2_r  <= '0;
         lclk_d_r <= 1'b1; // overwritten from the cleared sync2_r, so a clock high at release is still seen as a rise
      end else begin
         sync1_r  <= {datapath_reset_n, rx_defect, tx_byte_start,
                      rx_byte_start, rx_trace_bit, line_clk};
         sync2_r  <= sync1_r;
         lclk_d_r <= sync2_r[ett_pkg::SI_LCLK];
      end
   end

   assign lclk_rise = sync2_r[ett_pkg::SI_LCLK] & ~lclk_d_r;
   assign dp_run    = sync2_r[ett_pkg::SI_DPRST];

   // ****************************************************************
   // register file state
   // ****************************************************************
   logic [7:0]       ctrl_r, ctrl_nxt;
   logic [15:0][7:0] tx_mem_r;
   logic [15:0][7:0] exp_id_r, exp_id_nxt;
   logic [15:0][7:0] cur_id_r, cur_id_nxt;
   logic [15:0][7:0] prv_id_r, prv_id_nxt;
   logic [15:0][7:0] acc_id_r, acc_id_nxt;
   logic             change_r, change_nxt;
   logic [31:0]      rdata_r, rdata_nxt;

   logic             acc_wr;
   logic             acc_rd;
   logic             hit_ctrl, hit_stat, hit_tx, hit_cur, hit_acc, hit_exp;
   logic [3:0]       widx;
   logic             id_update;

   // software-visible status collected from the datapath
   logic             idle_r, unst_r, mism_r;
   ett_pkg::ett_align_type al_r, al_nxt;

   assign acc_wr   = psel & penable & pwrite;
   assign acc_rd   = psel & ~penable & ~pwrite;
   assign hit_ctrl = (paddr == ett_pkg::OFF_CTRL);
   assign hit_stat = (paddr == ett_pkg::OFF_STAT);
   assign hit_tx   = in_region(paddr, ett_pkg::OFF_TXID);
   assign hit_cur  = in_region(paddr, ett_pkg::OFF_RXCUR);
   assign hit_acc  = in_region(paddr, ett_pkg::OFF_RXACC);
   assign hit_exp  = in_region(paddr, ett_pkg::OFF_RXEXP);
   assign widx     = paddr[5:2];

   // zero wait states; unmapped address answers with an error
   assign pready  = 1'b1;
   assign pslverr = psel & penable &
                    ~(hit_ctrl | hit_stat | hit_tx | hit_cur | hit_acc | hit_exp);
   assign prdata  = rdata_r;

   // control, expected identifier, change flag and read data next values
   always_comb begin
      ctrl_nxt   = ctrl_r;
      exp_id_nxt = exp_id_r;
      change_nxt = change_r;
      rdata_nxt  = rdata_r;
      if (acc_wr && hit_ctrl) begin
         ctrl_nxt = pwdata[7:0];
      end
      if (acc_wr && hit_exp) begin
         exp_id_nxt[widx] = pwdata[7:0];
      end
      // write one clears change; a new update in the same cycle wins
      if (acc_wr && hit_stat && pwdata[ett_pkg::SB_CHANGE]) begin
         change_nxt = 1'b0;
      end
      if (id_update) begin
         change_nxt = 1'b1;
      end
      // read data is captured in the setup phase so it comes from flops
      if (acc_rd) begin
         rdata_nxt = 32'h0000_0000;
         if (hit_ctrl) rdata_nxt[7:0] = ctrl_r;
         if (hit_stat) rdata_nxt[4:0] = {al_r == ett_pkg::AL_LOCKED, mism_r,
                                          unst_r, idle_r, change_r};
         if (hit_tx)   rdata_nxt[7:0] = tx_mem_r[widx];
         if (hit_cur)  rdata_nxt[7:0] = cur_id_r[widx];
         if (hit_acc)  rdata_nxt[7:0] = acc_id_r[widx];
         if (hit_exp)  rdata_nxt[7:0] = exp_id_r[widx];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r   <= ett_pkg::CTRL_RESET;
         exp_id_r <= '0;
         change_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
      end else begin
         ctrl_r   <= ctrl_nxt;
         exp_id_r <= exp_id_nxt;
         change_r <= change_nxt;
         rdata_r  <= rdata_nxt;
      end
   end

   // transmit identifier memory: deliberately without any reset
   always_ff @(posedge pclk) begin
      if (acc_wr && hit_tx) begin
         tx_mem_r[widx] <= pwdata[7:0];
      end
   end

   // ****************************************************************
   // transmit trace processor
   // ****************************************************************
   logic [3:0] tx_idx_r, tx_idx_nxt;
   logic [7:0] tx_sh_r, tx_sh_nxt;
   logic       tx_bit_r, tx_bit_nxt;
   logic [7:0] tx_proc;

   // build the serial-order byte: bit 7 leaves first
   always_comb begin
      tx_proc = ctrl_r[ett_pkg::CB_TX_REORDER] ? bit_rev(tx_mem_r[tx_idx_r])
                                               : tx_mem_r[tx_idx_r];
      if (ctrl_r[ett_pkg::CB_TX_ALIGN]) begin
         tx_proc[7] = (tx_idx_r == 4'h0);
      end
      if (ctrl_r[ett_pkg::CB_TX_INVERT]) begin
         tx_proc = ~tx_proc;
      end
      if (ctrl_r[ett_pkg::CB_TX_IDLE]) begin
         tx_proc = 8'h00;
      end
   end

   // a byte start loads the next byte, other line edges shift it out
   always_comb begin
      tx_idx_nxt = tx_idx_r;
      tx_sh_nxt  = tx_sh_r;
      tx_bit_nxt = tx_bit_r;
      if (!dp_run) begin
         tx_idx_nxt = 4'h0;
         tx_sh_nxt  = 8'h00;
         tx_bit_nxt = 1'b0;
      end else if (lclk_rise) begin
         if (sync2_r[ett_pkg::SI_TXSTART]) begin
            tx_bit_nxt = tx_proc[7];
            tx_sh_nxt  = {tx_proc[6:0], 1'b0};
            tx_idx_nxt = tx_idx_r + 4'h1;
         end else begin
            tx_bit_nxt = tx_sh_r[7];
            tx_sh_nxt  = {tx_sh_r[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_idx_r <= 4'h0;
         tx_sh_r  <= 8'h00;
         tx_bit_r <= 1'b0;
      end else begin
         tx_idx_r <= tx_idx_nxt;
         tx_sh_r  <= tx_sh_nxt;
         tx_bit_r <= tx_bit_nxt;
      end
   end

   assign tx_trace_bit = tx_bit_r;

   // ****************************************************************
   // receive byte assembly and alignment
   // ****************************************************************
   logic [6:0] rx_sh_r, rx_sh_nxt;
   logic [3:0] rx_cnt_r, rx_cnt_nxt;
   logic [3:0] rx_idx_r, rx_idx_nxt;
   logic       eval_r, eval_nxt;
   logic       rx_bit;
   logic       byte_done;
   logic [7:0] rx_ser;
   logic       multiframe_align_bit;
   logic       store;
   logic [3:0] slot;
   logic       align_en;

   assign align_en = ctrl_r[ett_pkg::CB_RX_ALIGN];
   // inversion acts on the line data first, a defect then forces ones over the result
   assign rx_bit   = sync2_r[ett_pkg::SI_DEFECT] ? 1'b1 :
                     (sync2_r[ett_pkg::SI_RXBIT] ^ ctrl_r[ett_pkg::CB_RX_INVERT]);

   // shift in bits; eighth bit after a byte start completes a byte
   always_comb begin
      rx_sh_nxt  = rx_sh_r;
      rx_cnt_nxt = rx_cnt_r;
      byte_done  = 1'b0;
      rx_ser     = {rx_sh_r, rx_bit};
      if (lclk_rise) begin
         rx_sh_nxt  = {rx_sh_r[5:0], rx_bit};
         rx_cnt_nxt = sync2_r[ett_pkg::SI_RXSTART] ? 4'h1 :
                      ((rx_cnt_r == 4'h0) ? 4'h0 : sat_inc(rx_cnt_r));
         byte_done  = (rx_cnt_nxt == 4'h8);
      end
      if (!dp_run) begin
         rx_sh_nxt  = 7'h00;
         rx_cnt_nxt = 4'h0;
      end
   end

   assign multiframe_align_bit = rx_ser[7];

   // alignment search and storage slot choice
   always_comb begin
      al_nxt     = al_r;
      rx_idx_nxt = rx_idx_r;
      store      = 1'b0;
      slot       = rx_idx_r;
      eval_nxt   = 1'b0;
      if (byte_done) begin
         store = 1'b1;
         if (!align_en) begin
            al_nxt     = ett_pkg::AL_HUNT;
            rx_idx_nxt = rx_idx_r + 4'h1;
            eval_nxt   = (rx_idx_r == 4'hF);
         end else begin
            unique case (al_r)
               ett_pkg::AL_HUNT: begin
                  store = multiframe_align_bit;
                  slot  = 4'h0;
                  if (multiframe_align_bit) begin
                     al_nxt     = ett_pkg::AL_VERIFY;
                     rx_idx_nxt = 4'h1;
                  end
               end
               ett_pkg::AL_VERIFY: begin
                  if (multiframe_align_bit) begin
                     slot       = 4'h0; // restart on a fresh start bit
                     rx_idx_nxt = 4'h1;
                  end else begin
                     rx_idx_nxt = rx_idx_r + 4'h1;
                     if (rx_idx_r == 4'hF) begin
                        al_nxt   = ett_pkg::AL_LOCKED;
                        eval_nxt = 1'b1;
                     end
                  end
               end
               ett_pkg::AL_LOCKED: begin
                  if (multiframe_align_bit != (rx_idx_r == 4'h0)) begin
                     // broken pattern: drop lock, reuse a start bit if seen
                     store      = multiframe_align_bit;
                     slot       = 4'h0;
                     al_nxt     = multiframe_align_bit ? ett_pkg::AL_VERIFY : ett_pkg::AL_HUNT;
                     rx_idx_nxt = multiframe_align_bit ? 4'h1 : 4'h0;
                  end else begin
                     rx_idx_nxt = rx_idx_r + 4'h1;
                     eval_nxt   = (rx_idx_r == 4'hF);
                  end
               end
            endcase
         end
      end
      if (!dp_run) begin
         al_nxt     = ett_pkg::AL_HUNT;
         rx_idx_nxt = 4'h0;
         store      = 1'b0;
         eval_nxt   = 1'b0;
      end
   end

   // current identifier storage in register bit order
   always_comb begin
      cur_id_nxt = cur_id_r;
      if (store) begin
         cur_id_nxt[slot] = ctrl_r[ett_pkg::CB_RX_REORDER] ? bit_rev(rx_ser)
                                                           : rx_ser;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_sh_r  <= 7'h00;
         rx_cnt_r <= 4'h0;
         rx_idx_r <= 4'h0;
         al_r     <= ett_pkg::AL_HUNT;
         eval_r   <= 1'b0;
         cur_id_r <= '0;
      end else begin
         rx_sh_r  <= rx_sh_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         rx_idx_r <= rx_idx_nxt;
         al_r     <= al_nxt;
         eval_r   <= eval_nxt;
         cur_id_r <= cur_id_nxt;
      end
   end

   // ****************************************************************
   // identifier acceptance, idle, unstable and mismatch
   // ****************************************************************
   logic [3:0] same_c_r, same_c_nxt;
   logic [3:0] zero_c_r, zero_c_nxt;
   logic [3:0] nz_c_r, nz_c_nxt;
   logic [3:0] un_c_r, un_c_nxt;
   logic       valid_r, valid_nxt;
   logic       idle_nxt, unst_nxt, mism_nxt;
   logic       id_zero, id_same, id_known;
   logic [7:0] mas_mask;
   logic       diff;

   assign id_zero  = (cur_id_r == '0);
   assign id_same  = (cur_id_r == prv_id_r);
   assign id_known = valid_r && (cur_id_r == acc_id_r);
   // alignment bit position depends on the receive bit order
   assign mas_mask = ctrl_r[ett_pkg::CB_RX_REORDER] ? 8'hFE : 8'h7F;

   // seven-bit comparison of all sixteen bytes
   always_comb begin
      diff = 1'b0;
      for (int i = 0; i < ett_pkg::ID_BYTES; i++) begin
         diff = diff | (((acc_id_r[i] ^ exp_id_r[i]) & mas_mask) != 8'h00);
      end
   end

   // per-identifier persistence counting, done once per complete identifier
   always_comb begin
      same_c_nxt = same_c_r;
      zero_c_nxt = zero_c_r;
      nz_c_nxt   = nz_c_r;
      un_c_nxt   = un_c_r;
      prv_id_nxt = prv_id_r;
      acc_id_nxt = acc_id_r;
      valid_nxt  = valid_r;
      idle_nxt   = idle_r;
      unst_nxt   = unst_r;
      id_update  = 1'b0;
      if (eval_r) begin
         same_c_nxt = id_zero ? 4'h0 : (id_same ? sat_inc(same_c_r) : 4'h1);
         zero_c_nxt = id_zero ? sat_inc(zero_c_r) : 4'h0;
         nz_c_nxt   = id_zero ? 4'h0 : sat_inc(nz_c_r);
         un_c_nxt   = (id_same || id_known) ? 4'h0 : sat_inc(un_c_r);
         prv_id_nxt = cur_id_r;
         if (same_c_nxt >= DECL_C && !id_known) begin
            acc_id_nxt = cur_id_r;
            valid_nxt  = 1'b1;
            id_update  = 1'b1;
         end
         if (nz_c_nxt >= DECL_C) begin
            idle_nxt = 1'b0;
            unst_nxt = 1'b0;
         end
         if (zero_c_nxt >= DECL_C) begin
            idle_nxt = 1'b1;
            unst_nxt = 1'b0;
         end
         if (un_c_nxt >= UNST_C) begin
            unst_nxt = 1'b1;
            idle_nxt = 1'b0;
         end
      end
      // comparison only while enabled, aligned mode on and a held id exists
      mism_nxt = ctrl_r[ett_pkg::CB_CMP_EN] && align_en && valid_r && diff;
      if (!dp_run) begin
         same_c_nxt = 4'h0;
         zero_c_nxt = 4'h0;
         nz_c_nxt   = 4'h0;
         un_c_nxt   = 4'h0;
         valid_nxt  = 1'b0;
         idle_nxt   = 1'b0;
         unst_nxt   = 1'b0;
         mism_nxt   = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         same_c_r <= 4'h0;
         zero_c_r <= 4'h0;
         nz_c_r   <= 4'h0;
         un_c_r   <= 4'h0;
         prv_id_r <= '0;
         acc_id_r <= '0;
         valid_r  <= 1'b0;
         idle_r   <= 1'b0;
         unst_r   <= 1'b0;
         mism_r   <= 1'b0;
      end else begin
         same_c_r <= same_c_nxt;
         zero_c_r <= zero_c_nxt;
         nz_c_r   <= nz_c_nxt;
         un_c_r   <= un_c_nxt;
         prv_id_r <= prv_id_nxt;
         acc_id_r <= acc_id_nxt;
         valid_r  <= valid_nxt;
         idle_r   <= idle_nxt;
         unst_r   <= unst_nxt;
         mism_r   <= mism_nxt;
      end
   end

endmodule

// File: ett_pkg.sv
// ****************************************************************
// trail trace controller constants
// ****************************************************************
package ett_pkg;
   // identifier geometry
   localparam int          ID_BYTES       = 16;
   // register byte offsets
   localparam logic [11:0] OFF_CTRL       = 12'h000;
   localparam logic [11:0] OFF_STAT       = 12'h004;
   localparam logic [11:0] OFF_TXID       = 12'h040;
   localparam logic [11:0] OFF_RXCUR      = 12'h080;
   localparam logic [11:0] OFF_RXACC      = 12'h0C0;
   localparam logic [11:0] OFF_RXEXP      = 12'h100;
   localparam logic [11:0] ID_SPAN        = 12'h040;
   // control register fields
   localparam int          CB_TX_REORDER  = 0;
   localparam int          CB_TX_ALIGN    = 1;
   localparam int          CB_TX_INVERT   = 2;
   localparam int          CB_TX_IDLE     = 3;
   localparam int          CB_RX_INVERT   = 4;
   localparam int          CB_RX_REORDER  = 5;
   localparam int          CB_RX_ALIGN    = 6;
   localparam int          CB_CMP_EN      = 7;
   localparam logic [7:0]  CTRL_RESET     = 8'h00;
   // status register fields
   localparam int          SB_CHANGE      = 0;
   localparam int          SB_IDLE        = 1;
   localparam int          SB_UNSTABLE    = 2;
   localparam int          SB_MISMATCH    = 3;
   localparam int          SB_ALIGNED     = 4;
   // synchroniser input positions
   localparam int          SI_LCLK        = 0;
   localparam int          SI_RXBIT       = 1;
   localparam int          SI_RXSTART     = 2;
   localparam int          SI_TXSTART     = 3;
   localparam int          SI_DEFECT      = 4;
   localparam int          SI_DPRST       = 5;
   localparam int          SI_WIDTH       = 6;
   // persistence counts
   localparam int          DECLARE_COUNT  = 5;
   localparam int          UNSTABLE_COUNT = 8;
   // timing: line clock must stay in each level long enough to be sampled
   localparam int          CLK_PERIOD_NS  = 4;
   localparam int          LINK_PERIOD_NS = 80;
   localparam int          LINK_HALF_CYC  = (LINK_PERIOD_NS / 2) / CLK_PERIOD_NS;
   localparam int          MIN_HALF_CYC   = 3;
   // receive alignment states
   typedef enum logic [1:0] {AL_HUNT, AL_VERIFY, AL_LOCKED} ett_align_type;
endpackage

// File: ett_framer_model.sv
`timescale 1ns/1ps
// **********
// framer overhead path model
// **********
module ett_framer_model (
   input  wire logic         run,
   input  wire logic [127:0] rx_id,
   input  wire logic         tx_trace_bit,
   output logic              line_clk,
   output logic              rx_trace_bit,
   output logic              rx_byte_start,
   output logic              tx_byte_start,
   output logic [127:0]      tx_id,
   output logic [15:0]       ids
);
   logic [127:0] sh;
   int           n;
   // clock stands low until traffic starts; data move on the falling edge
   initial begin
      {line_clk, rx_trace_bit, rx_byte_start, tx_byte_start} = 4'h0;
      {tx_id, sh, ids} = '0;
      n = 0;
      wait (run);
      #1;
      forever begin
         #40;
         line_clk      = 1'b0;
         rx_byte_start = (n % 8 == 0);
         tx_byte_start = rx_byte_start;
         rx_trace_bit  = rx_id[127 - n % 128];
         #40;
         line_clk      = 1'b1;
         sh            = {sh[126:0], tx_trace_bit};
         // a bit is taken one edge late, so whole identifiers land on 128
         if (n > 0 && n % 128 == 0) begin
            tx_id = sh;
            ids   = ids + 16'h0001;
         end
         n++;
      end
   end
endmodule

// File: ett_trail_trace_properties.sv
`timescale 1ns/1ps
// **********
// port properties of the trail trace block
// **********
module ett_trail_trace_properties (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        line_clk,
   input wire logic        tx_trace_bit
);
   logic [7:0] ctrl_r, ctrl_nxt;
   logic [8:0] quiet_r, quiet_nxt;
   logic [3:0] since_r, since_nxt;
   logic       lclk_r;
   logic       bad_addr;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // control shadow; idle is only judged once a whole byte has gone by
   always_comb begin
      ctrl_nxt  = ctrl_r;
      quiet_nxt = (quiet_r == 9'h1FF) ? quiet_r : quiet_r + 9'h001;
      since_nxt = (since_r == 4'hF) ? since_r : since_r + 4'h1;
      if (psel && penable && pwrite && paddr == ett_pkg::OFF_CTRL) begin
         ctrl_nxt  = pwdata[7:0];
         quiet_nxt = 9'h000;
      end
      if (line_clk && !lclk_r) begin
         since_nxt = 4'h0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r  <= 8'h00;
         quiet_r <= 9'h000;
         since_r <= 4'hF;
         lclk_r  <= 1'b1;
      end else begin
         ctrl_r  <= ctrl_nxt;
         quiet_r <= quiet_nxt;
         since_r <= since_nxt;
         lclk_r  <= line_clk;
      end
   end
   // mapped: control, status and four word-aligned identifier windows
   assign bad_addr = (paddr[1:0] != 2'h0) || !(paddr <= ett_pkg::OFF_STAT ||
      (paddr >= ett_pkg::OFF_TXID && paddr < ett_pkg::OFF_RXEXP + ett_pkg::ID_SPAN));
   sequence ctrl_rd;
      psel && !penable && !pwrite && paddr == ett_pkg::OFF_CTRL;
   endsequence
   sequence bad_rd;
      psel && !penable && !pwrite && bad_addr;
   endsequence
   ready_high_a: assert property (pready) else $error("pready low");
   err_unmapped_a: assert property (psel && penable |-> pslverr == bad_addr)
      else $error("pslverr wrong");
   err_quiet_a: assert property (!(psel && penable) |-> !pslverr)
      else $error("stray pslverr");
   rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("prdata moved");
   rdata_upper_a: assert property (prdata[31:8] == 24'h0) else $error("upper bits");
   bad_read_a: assert property (bad_rd |=> prdata == 32'h0) else $error("unmapped data");
   ctrl_back_a: assert property (ctrl_rd |=> prdata[7:0] == ctrl_r)
      else $error("ctrl readback");
   tx_idle_a: assert property (quiet_r == 9'h1FF && ctrl_r[ett_pkg::CB_TX_IDLE] |-> !tx_trace_bit)
      else $error("idle not zero");
   tx_timing_a: assert property ($changed(tx_trace_bit) |-> since_r inside {[1:6]})
      else $error("tx bit off line edge");
endmodule
bind ett_trail_trace ett_trail_trace_properties ett_trail_trace_properties_i (.pclk(pclk),
   .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_clk(line_clk),
   .tx_trace_bit(tx_trace_bit));

// File: ett_trail_trace_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
   $display("BAD %0t got %h expected %h", $time, g, e); end end
// **********
// trail trace bench
// **********
module ett_trail_trace_tb;
   logic         pclk, presetn, psel, penable, pwrite, dp_rst_n, run, rx_defect;
   logic         pready, pslverr, line_clk, rx_bit, rx_bs, tx_bs, tx_bit;
   logic [11:0]  paddr;
   logic [31:0]  pwdata, prdata, rd;
   logic [127:0] rx_id, tx_id, txv;
   logic [15:0]  ids, t0;
   logic [7:0]   ctrl_tab [5] = '{8'hC2, 8'hC2, 8'hC2, 8'hE5, 8'h0E};
   int           wait_tab [5] = '{2, 6, 2, 2, 2};
   int           fails = 0;
   int           n_compared = 0;
   ett_trail_trace ett_trail_trace_i (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .datapath_reset_n(dp_rst_n), .line_clk(line_clk), .rx_trace_bit(rx_bit),
      .rx_byte_start(rx_bs), .rx_defect(rx_defect), .tx_byte_start(tx_bs),
      .tx_trace_bit(tx_bit));
   ett_framer_model ett_framer_model_i (.run(run), .rx_id(rx_id), .tx_trace_bit(tx_bit),
      .line_clk(line_clk), .rx_trace_bit(rx_bit), .rx_byte_start(rx_bs),
      .tx_byte_start(tx_bs), .tx_id(tx_id), .ids(ids));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // swap bit order inside every byte
   function automatic logic [127:0] rev(input logic [127:0] v);
      for (int i = 0; i < 128; i++) rev[i] = v[i ^ 7];
   endfunction
   // expected line identifier under a control byte
   function automatic logic [127:0] tx_exp(input logic [127:0] id, input logic [7:0] c);
      tx_exp = c[ett_pkg::CB_TX_REORDER] ? rev(id) : id;
      for (int i = 0; i < 16; i++)
         if (c[ett_pkg::CB_TX_ALIGN]) tx_exp[127 - 8 * i] = (i == 0);
      if (c[ett_pkg::CB_TX_INVERT]) tx_exp = ~tx_exp;
      if (c[ett_pkg::CB_TX_IDLE]) tx_exp = '0;
   endfunction
   // one transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd       = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr_id(input logic [11:0] base, input logic [127:0] v);
      for (int i = 0; i < 16; i++) apb(1'b1, base + 12'(4 * i), 32'(v[127 - 8 * i -: 8]));
   endtask
   task automatic chk_id(input logic [11:0] base, input logic [127:0] v);
      for (int i = 0; i < 16; i++) begin
         apb(1'b0, base + 12'(4 * i), 32'h0);
         `CHK(rd, 32'(v[127 - 8 * i -: 8]))
      end
   endtask
   task automatic end_of_test;
      $display("compared %0d mismatched %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // fourteen identifiers take about 36000 cycles
   initial begin
      repeat (80000) @(posedge pclk);
      fails++;
      $display("BAD %0t watchdog expired", $time);
      end_of_test;
   end
   initial begin
      {presetn, psel, penable, pwrite, dp_rst_n, run, rx_defect} = 7'h00;
      {paddr, pwdata, rd} = '0;
      void'($urandom(5024));
      for (int i = 0; i < 128; i++) {txv[i], rx_id[i]} = 2'($urandom);
      for (int i = 0; i < 16; i++) rx_id[127 - 8 * i] = (i == 0);
      repeat (12) @(posedge pclk);
      presetn  <= 1'b1;
      dp_rst_n <= 1'b1;
      repeat (4) @(posedge pclk);
      // control, status and an unmapped word all read zero
      for (int k = 0; k < 3; k++) begin
         apb(1'b0, (k == 2) ? 12'h200 : 12'(4 * k), 32'h0);
         `CHK(rd, 32'h0)
      end
      wr_id(ett_pkg::OFF_TXID, txv);
      run <= 1'b1;
      for (int s = 0; s < 5; s++) begin
         apb(1'b1, ett_pkg::OFF_CTRL, 32'(ctrl_tab[s]));
         if (s == 2) wr_id(ett_pkg::OFF_RXEXP, rx_id ^ {16{8'h80}});
         rx_defect <= (s == 4);
         t0 = ids;
         while (ids < t0 + 16'(wait_tab[s])) @(posedge pclk);
         `CHK(tx_id, tx_exp(txv, ctrl_tab[s]))
         apb(1'b0, ett_pkg::OFF_STAT, 32'h0);
         if (s == 0 || s == 2) `CHK(rd[ett_pkg::SB_MISMATCH], 1'b0)
         if (s == 1) begin
            `CHK(rd[4:0], 5'h19)
            chk_id(ett_pkg::OFF_RXACC, rx_id);
         end
         if (s == 3) chk_id(ett_pkg::OFF_RXCUR, rev(rx_id));
         if (s == 4) chk_id(ett_pkg::OFF_RXCUR, '1);
      end
      // transmit identifier must survive a reset
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk_id(ett_pkg::OFF_TXID, txv);
      end_of_test;
   end
endmodule
